// ### src/sip_regs.vh
`ifndef SIP_REGS_VH
`define SIP_REGS_VH

// channel and pin counts
`define SIP_CHANS 8
`define SIP_PINS 20
`define SIP_PIN_SEL_W 5
`define SIP_WORD_W 32
`define SIP_PAR_W 20
`define SIP_PAR_CHAN 3'h7

// shared fifo shape
`define SIP_FIFO_DEPTH 4'h8
`define SIP_FIFO_AW 3

// framing formats
`define SIP_FMT_I2S 2'h0
`define SIP_FMT_LJ 2'h1
`define SIP_FMT_RJ 2'h2

// sample width codes
`define SIP_WSEL_32 3'h0
`define SIP_WSEL_24 3'h1
`define SIP_WSEL_20 3'h2
`define SIP_WSEL_18 3'h3
`define SIP_WSEL_16 3'h4

// bits carried by one half frame
`define SIP_HALF_BITS 6'h20

`endif

// ### src/sip_chan.v
`include "sip_regs.vh"

module sip_chan
(
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// control
	input wire en,
	input wire [1:0] fmt,
	input wire [2:0] wsel,
	// routed, synchronised link signals
	input wire bclk,
	input wire fsync,
	input wire sdat,
	// received half frame
	output reg word_stb,
	output reg [31:0] word
);

reg bclk_d;
reg fs_bit;
reg eff_prev;
reg primed;
reg [31:0] sh;
reg [5:0] cnt;

wire rise = bclk & ~bclk_d;
// i2s starts its half one bit clock after the frame sync change
wire eff = (fmt == `SIP_FMT_I2S) ? fs_bit : fsync;

// illegal width codes for a format fall back to 24 bits
function [5:0] width_of;
	input [1:0] f;
	input [2:0] w;
	begin
		case (w)
			`SIP_WSEL_32: width_of = (f == `SIP_FMT_RJ) ? 6'h18 : 6'h20;
			`SIP_WSEL_24: width_of = 6'h18;
			`SIP_WSEL_20: width_of = (f == `SIP_FMT_RJ) ? 6'h14 : 6'h18;
			`SIP_WSEL_18: width_of = (f == `SIP_FMT_RJ) ? 6'h12 : 6'h18;
			`SIP_WSEL_16: width_of = (f == `SIP_FMT_RJ) ? 6'h10 : 6'h18;
			default: width_of = 6'h18;
		endcase
	end
endfunction

// samples leave msb aligned in the 32-bit word
function [31:0] align;
	input [31:0] s;
	input [5:0] n;
	input [1:0] f;
	input [5:0] w;
	reg [31:0] m;
	begin
		m = (n >= `SIP_HALF_BITS) ? s : (s << (`SIP_HALF_BITS - n));
		if (f == `SIP_FMT_RJ)
			align = s << (`SIP_HALF_BITS - w);
		else
			align = m & ~(32'hffffffff >> w);
	end
endfunction

always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		bclk_d <= 1'b0;
		fs_bit <= 1'b0;
		eff_prev <= 1'b0;
		primed <= 1'b0;
		sh <= 32'h0;
		cnt <= 6'h0;
		word_stb <= 1'b0;
		word <= 32'h0;
	end
	else
	begin
		bclk_d <= bclk;
		word_stb <= 1'b0;
		if (!en)
		begin
			primed <= 1'b0;
			cnt <= 6'h0;
			// keep tracking the pin so a stale level fakes no half start after enable
			fs_bit <= fsync;
			eff_prev <= eff;
		end
		else if (rise)
		begin
			fs_bit <= fsync;
			eff_prev <= eff;
			if (eff != eff_prev)
			begin
				// the first half after enable is partial and is thrown away
				primed <= 1'b1;
				word_stb <= primed;
				word <= align(sh, cnt, fmt, width_of(fmt, wsel));
				sh <= {31'h0, sdat};
				cnt <= 6'h1;
			end
			else if (fmt == `SIP_FMT_RJ || cnt < `SIP_HALF_BITS)
			begin
				// right justified keeps the last bits, the others the first
				sh <= {sh[30:0], sdat};
				cnt <= (cnt < `SIP_HALF_BITS) ? cnt + 6'h1 : cnt;
			end
		end
	end
end

endmodule // sip_chan

// ### src/sip_top.v
`include "sip_regs.vh"

module sip_top
(
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// audio pins
	input wire [19:0] routable_audio_pins,
	// signal routing matrix, five bits per channel
	input wire [39:0] route_clk_sel,
	input wire [39:0] route_fs_sel,
	input wire [39:0] route_dat_sel,
	// channel setup
	input wire [7:0] chan_en,
	input wire [15:0] fmt_sel,
	input wire [23:0] width_sel,
	input wire par_mode,
	// dma side
	output reg [7:0] dma_req,
	output reg [31:0] dma_data,
	input wire dma_ack,
	// status
	output reg overflow,
	input wire overflow_clr
);

reg [19:0] pin_s1;
reg [19:0] pin_s2;
wire [7:0] ch_stb;
wire [255:0] ch_word;
wire [7:0] r_clk;
wire [7:0] r_fs;
wire [7:0] r_dat;

reg [7:0] pend;
reg [31:0] pend_word [0:7];
reg [34:0] mem [0:7];
reg [2:0] wr_ptr;
reg [2:0] rd_ptr;
reg [3:0] count;
reg out_valid;

reg par_clk_d;
reg par_stb;
reg [31:0] par_word;

reg gnt_any;
reg [2:0] gnt;
integer i;

// pins cross into ref_clk through two flops before the routing matrix
always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		pin_s1 <= 20'h0;
		pin_s2 <= 20'h0;
	end
	else
	begin
		pin_s1 <= routable_audio_pins;
		pin_s2 <= pin_s1;
	end
end

// a selector past the last pin reads low
function pick;
	input [19:0] p;
	input [4:0] s;
	begin
		pick = (s < 5'h14) ? p[s] : 1'b0;
	end
endfunction

// pointers wrap at the fifo depth, which is a power of two
function [2:0] adv;
	input [2:0] p;
	begin
		adv = p + 3'h1;
	end
endfunction

genvar g;
generate
	for (g = 0; g < `SIP_CHANS; g = g + 1)
	begin : ch
		assign r_clk[g] = pick(pin_s2, route_clk_sel[5*g+4:5*g]);
		assign r_fs[g] = pick(pin_s2, route_fs_sel[5*g+4:5*g]);
		assign r_dat[g] = pick(pin_s2, route_dat_sel[5*g+4:5*g]);
		sip_chan u_chan
		(
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.en(chan_en[g] & ~(par_mode && g == `SIP_PAR_CHAN)),
			.fmt(fmt_sel[2*g+1:2*g]),
			.wsel(width_sel[3*g+2:3*g]),
			.bclk(r_clk[g]),
			.fsync(r_fs[g]),
			.sdat(r_dat[g]),
			.word_stb(ch_stb[g]),
			.word(ch_word[32*g+31:32*g])
		);
	end
endgenerate

// capture edge found on the synchronised pin, same as the serial channels
wire par_rise = r_clk[`SIP_PAR_CHAN] & ~par_clk_d;

// parallel capture takes the top channel's clock and frame sync as qualifier;
// pins used as its clock or qualifier still appear in the captured word
always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		par_clk_d <= 1'b0;
		par_stb <= 1'b0;
		par_word <= 32'h0;
	end
	else
	begin
		par_clk_d <= r_clk[`SIP_PAR_CHAN];
		par_stb <= 1'b0;
		if (par_mode && chan_en[`SIP_PAR_CHAN] && par_rise && r_fs[`SIP_PAR_CHAN])
		begin
			par_stb <= 1'b1;
			par_word <= {pin_s2, 12'h0};
		end
	end
end

// fixed priority pick, one word a cycle; eight cycles drains all channels,
// well inside one bit clock, so a pending word is never overwritten in use
always @*
begin
	gnt_any = 1'b0;
	gnt = 3'h0;
	for (i = `SIP_CHANS - 1; i >= 0; i = i - 1)
	begin
		if (pend[i])
		begin
			gnt_any = 1'b1;
			gnt = i[2:0];
		end
	end
end

wire pop = (count != 4'h0) && (!out_valid || dma_ack);
wire push = gnt_any && (count != `SIP_FIFO_DEPTH);
wire drop = gnt_any && (count == `SIP_FIFO_DEPTH);

always @(posedge ref_clk or negedge rst_n)
begin
	if (!rst_n)
	begin
		pend <= 8'h0;
		for (i = 0; i < `SIP_CHANS; i = i + 1)
		begin
			pend_word[i] <= 32'h0;
			mem[i] <= 35'h0;
		end
		wr_ptr <= 3'h0;
		rd_ptr <= 3'h0;
		count <= 4'h0;
		overflow <= 1'b0;
		out_valid <= 1'b0;
		dma_req <= 8'h0;
		dma_data <= 32'h0;
	end
	else
	begin
		for (i = 0; i < `SIP_CHANS; i = i + 1)
		begin
			if (gnt_any && gnt == i[2:0])
				pend[i] <= 1'b0;
			if (i == `SIP_PAR_CHAN && par_stb)
			begin
				pend[i] <= 1'b1;
				pend_word[i] <= par_word;
			end
			else if (ch_stb[i])
			begin
				pend[i] <= 1'b1;
				pend_word[i] <= ch_word[32*i+:32];
			end
		end
		if (push)
		begin
			mem[wr_ptr] <= {gnt, pend_word[gnt]};
			wr_ptr <= adv(wr_ptr);
		end
		count <= count + {3'h0, push} - {3'h0, pop};
		// set wins over a clear in the same cycle
		if (drop)
			overflow <= 1'b1;
		else if (overflow_clr)
			overflow <= 1'b0;
		if (pop)
		begin
			rd_ptr <= adv(rd_ptr);
			out_valid <= 1'b1;
			dma_data <= mem[rd_ptr][31:0];
			dma_req <= 8'h1 << mem[rd_ptr][34:32];
		end
		else if (dma_ack)
		begin
			out_valid <= 1'b0;
			dma_req <= 8'h0;
		end
	end
end

endmodule // sip_top

// ### test/sip_src.sv
module sip_src
(
	// link lines, clock idles low between halves
	output logic bclk,
	output logic fs,
	output logic dat
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		bclk = 0;
		fs = 0;
		dat = 0;
	end
	// one half frame msb first; sync flips at its start, or with its lsb when early
	task send(input logic [31:0] w, input logic early);
		if (!early)
			fs = ~fs;
		for (int i = 31; i >= 0; i--)
		begin
			if (early && i == 0)
				fs = ~fs;
			dat = w[i];
			#80 bclk = 1;
			#80 bclk = 0;
		end
		dat = ~dat;
	endtask
	// one parallel capture, qualifier high around a single clock rise
	task strobe(input logic d);
		dat = d;
		fs = 1;
		#80 bclk = 1;
		#80 bclk = 0;
		fs = 0;
	endtask
endmodule // sip_src

// ### test/sip_top_assertions.sv
module sip_top_assertions
(
	// watched ports
	input wire ref_clk,
	input wire rst_n,
	input wire [7:0] dma_req,
	input wire [31:0] dma_data,
	input wire dma_ack,
	input wire overflow,
	input wire overflow_clr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	a_req_onehot: assert property ($onehot0(dma_req)) else $error("req not onehot");
	a_req_hold: assert property (|dma_req && !dma_ack |=> $stable(dma_req)) else $error("req moved");
	a_data_hold: assert property (|dma_req && !dma_ack |=> $stable(dma_data)) else $error("data moved");
	a_word_order: assert property ($changed(dma_req) && |dma_req |-> $past(dma_req) == 0 || $past(dma_ack))
		else $error("word skipped");
	a_quiet_reset: assert property ($rose(rst_n) |-> dma_req == 0 && !overflow) else $error("not quiet");
	a_ovf_sticky: assert property (overflow && !overflow_clr |=> overflow) else $error("flag lost");
	a_ovf_cause: assert property ($rose(overflow) |-> |dma_req) else $error("flag not full");
	a_ovf_clr: assert property (overflow && overflow_clr |=> !overflow || |dma_req) else $error("clr failed");
	cover property (dma_req[0] && dma_ack);
	cover property ($rose(overflow));
	cover property (overflow && overflow_clr);
	cover property (dma_req[7] && dma_ack);
endmodule // sip_top_assertions

bind sip_top sip_top_assertions chk_u(.ref_clk, .rst_n, .dma_req, .dma_data, .dma_ack, .overflow, .overflow_clr);

// ### test/sip_top_bench.sv
module sip_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst_n = 0, dma_ack = 0, overflow_clr = 0;
	logic [7:0] chan_en = 0;
	logic [15:0] fmt_sel = 0;
	logic [23:0] width_sel = 0;
	logic [39:0] route_clk_sel = 40'h0, route_fs_sel = 40'h1, route_dat_sel = 40'h2;
	logic par_mode = 0;
	wire [7:0] dma_req;
	wire [31:0] dma_data;
	wire overflow, bclk, fs, dat;
	localparam logic [31:0] pat = 32'h9a5c3e71;
	int fail_count = 0, n_compared = 0;
	sip_src src_u(.bclk(bclk), .fs(fs), .dat(dat));
	// channel 0 on pins 0, 1, 2
	sip_top dut_u(.ref_clk(ref_clk), .rst_n(rst_n), .routable_audio_pins({17'h0, dat, fs, bclk}),
		.route_clk_sel(route_clk_sel), .route_fs_sel(route_fs_sel), .route_dat_sel(route_dat_sel),
		.chan_en(chan_en), .fmt_sel(fmt_sel), .width_sel(width_sel), .par_mode(par_mode), .dma_req(dma_req),
		.dma_data(dma_data), .dma_ack(dma_ack), .overflow(overflow), .overflow_clr(overflow_clr));
	initial forever #5 ref_clk = ~ref_clk;
	task finish_test;
		if (fail_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task check(input logic c, input string m);
		n_compared++;
		if (c !== 1'b1)
		begin
			fail_count++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	// wait for a word and accept it with a one cycle ack
	task take(input logic [7:0] req, output logic [31:0] w);
		int i;
		// let the previous ack be sampled low before looking again
		@(posedge ref_clk) #1;
		for (i = 0; i < 4000 && dma_req === 8'h0; i++)
			@(posedge ref_clk) #1;
		if (i == 4000)
		begin
			fail_count++;
			$display("[ERR] %0t no word", $time);
			finish_test();
		end
		check(dma_req === req, "bad req");
		w = dma_data;
		dma_ack = 1;
		@(posedge ref_clk) #1 dma_ack = 0;
	endtask
	// the leading half may be dropped, so a zero word is skipped
	task run(input logic [1:0] f, input logic [2:0] ws, input int sh, input logic [31:0] m);
		logic [31:0] w;
		@(posedge ref_clk) #1 chan_en = 0;
		fmt_sel = {14'h0, f};
		width_sel = {21'h0, ws};
		@(posedge ref_clk) #1 chan_en = 8'h01;
		fork
			begin
				src_u.send(0, f == 2'h0);
				src_u.send(pat, f == 2'h0);
				src_u.send(~pat, f == 2'h0);
				src_u.send(0, f == 2'h0);
			end
			begin
				take(8'h01, w);
				if (w === 32'h0)
					take(8'h01, w);
				check(w === ((pat << sh) & m), "left word");
				take(8'h01, w);
				check(w === ((~pat << sh) & m), "right word");
			end
		join
	endtask
	// nine words fit: output stage plus eight fifo entries
	task ovf_case;
		logic [31:0] w;
		for (int k = 1; k <= 12; k++)
			src_u.send(k, 1'b0);
		src_u.send(0, 1'b0);
		check(overflow === 1'b1, "no overflow");
		for (int k = 0; k <= 8; k++)
		begin
			take(8'h01, w);
			check(w === k, "drain order");
		end
		repeat (20) @(posedge ref_clk);
		#1 check(dma_req === 8'h0 && overflow === 1'b1, "extra word");
		@(posedge ref_clk) #1 overflow_clr = 1;
		@(posedge ref_clk) #1 overflow_clr = 0;
		check(overflow === 1'b0, "flag stuck");
	endtask
	// channel 7 as parallel capture with its qualifier moved to pin 1, then a reset mid run
	task par_case;
		logic [31:0] w;
		@(posedge ref_clk) #1 chan_en = 8'h80;
		par_mode = 1;
		route_fs_sel[39:35] = 5'h01;
		src_u.strobe(1);
		take(8'h80, w);
		check(w === 32'h00007000, "parallel word");
		repeat (20) @(posedge ref_clk);
		#1 check(dma_req === 8'h0, "extra capture");
		@(posedge ref_clk) #1 rst_n = 0;
		#1 check(dma_data === 32'h0 && dma_req === 8'h0, "reset not clean");
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1;
		@(posedge ref_clk) #1 check(dma_req === 8'h0 && overflow === 1'b0, "not idle after reset");
	endtask
	initial
	begin
		repeat (2) @(posedge ref_clk);
		#1 rst_n = 1;
		run(2'h2, 3'h4, 16, 32'hffffffff);
		run(2'h0, 3'h1, 0, 32'hffffff00);
		run(2'h1, 3'h0, 0, 32'hffffffff);
		ovf_case();
		par_case();
		finish_test();
	end
endmodule // sip_top_bench
